// file: rtl/piso_shifter_pkg.sv
package piso_shifter_pkg;
  localparam int STAGE_COUNT = 8;
  localparam int SYNC_STAGES = 2;
  localparam int LINK_PERIOD_NS = 125;
  localparam int CLOCK_PERIOD_NS = 5;
  localparam int SAMPLES_PER_LINK = LINK_PERIOD_NS / CLOCK_PERIOD_NS;
endpackage : piso_shifter_pkg

// file: rtl/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Pins
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stable_q;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      stable_q <= '0;
    end else begin
      meta_q <= pinIn;
      stable_q <= meta_q;
    end
  end

  assign pinOut = stable_q;
endmodule : pin_sync
`default_nettype wire

// file: rtl/parallel_in_serial_out_shifter.sv
`timescale 1ns/100ps
`default_nettype none
module parallel_in_serial_out_shifter
  import piso_shifter_pkg::*;
#(
  parameter int STAGES = STAGE_COUNT
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Control pins
  input wire logic load_control_n,
  input wire logic linkClock,
  input wire logic clock_inhibit,
  input wire logic first_stage_data_in,
  // Parallel data pins
  input wire logic [STAGES-1:0] parallelIn,
  // Serial outputs
  output logic serialOut,
  output logic serialOutInv
);
  // ****************************************
  // Parameter check
  // ****************************************
  if (STAGES < 2) begin : g_bad_stages
    $error("STAGES must be at least two");
  end

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [STAGES+3:0] pinsRaw;
  logic [STAGES+3:0] pinsSync;
  // Load inverted so a cleared synchroniser reads idle
  assign pinsRaw = {parallelIn, first_stage_data_in, clock_inhibit, linkClock, ~load_control_n};

  pin_sync #(.WIDTH(STAGES + 4)) u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .pinIn(pinsRaw),
    .pinOut(pinsSync)
  );

  logic loadN;
  logic clkS;
  logic inhS;
  logic serS;
  logic [STAGES-1:0] parS;
  assign loadN = ~pinsSync[0];
  assign clkS = pinsSync[1];
  assign inhS = pinsSync[2];
  assign serS = pinsSync[3];
  assign parS = pinsSync[STAGES+3:4];

  // ****************************************
  // Edge detection
  // ****************************************
  logic clkPrev_q;
  logic inhPrev_q;
  logic shiftEvent;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      clkPrev_q <= 1'b1;
      inhPrev_q <= 1'b1;
    end else begin
      clkPrev_q <= clkS;
      inhPrev_q <= inhS;
    end
  end

  // Gated clock is OR of both pins; its rising edge shifts
  assign shiftEvent = loadN && !(clkPrev_q || inhPrev_q) && (clkS || inhS);

  // ****************************************
  // Stage register, no reset
  // ****************************************
  logic [STAGES-1:0] stages_q;

  always_ff @(posedge clock) begin
    if (!loadN) begin
      stages_q <= parS;
    end else if (shiftEvent) begin
      stages_q <= {stages_q[STAGES-2:0], serS};
    end
    // Otherwise hold; power-up contents undefined
  end

  // ****************************************
  // Serial outputs
  // ****************************************
  // Output flops keep data outputs registered
  always_ff @(posedge clock) begin
    serialOut <= stages_q[STAGES-1];
    serialOutInv <= ~stages_q[STAGES-1];
  end

  // ****************************************
  // Assertions
  // ****************************************
  // Set by the first load; stages hold known data from then on
  logic primed_q;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      primed_q <= 1'b0;
    end else if (!loadN) begin
      primed_q <= 1'b1;
    end
  end

  property p_load;
    @(posedge clock) disable iff (!reset_n) !loadN |=> stages_q == $past(parS);
  endproperty
  a_load: assert property (p_load) else $error("parallel load missed");

  property p_shift;
    @(posedge clock) disable iff (!reset_n)
      (shiftEvent && primed_q) |=> stages_q == {$past(stages_q[STAGES-2:0]), $past(serS)};
  endproperty
  a_shift: assert property (p_shift) else $error("shift wrong");

  property p_hold;
    @(posedge clock) disable iff (!reset_n)
      (primed_q && loadN && !shiftEvent) |=> $stable(stages_q);
  endproperty
  a_hold: assert property (p_hold) else $error("stages changed without cause");

  property p_inhibit_blocks;
    @(posedge clock) disable iff (!reset_n) (inhS && inhPrev_q) |-> !shiftEvent;
  endproperty
  a_inhibit_blocks: assert property (p_inhibit_blocks) else $error("shift while inhibited");

  property p_inh_edge;
    @(posedge clock) disable iff (!reset_n)
      (loadN && !clkS && !clkPrev_q && !inhPrev_q && inhS) |-> shiftEvent;
  endproperty
  a_inh_edge: assert property (p_inh_edge) else $error("inhibit edge did not shift");

  property p_clk_edge;
    @(posedge clock) disable iff (!reset_n)
      (loadN && !inhS && !inhPrev_q && !clkPrev_q && clkS) |-> shiftEvent;
  endproperty
  a_clk_edge: assert property (p_clk_edge) else $error("clock edge did not shift");

  property p_out;
    @(posedge clock) disable iff (!reset_n)
      primed_q |=> (serialOut == $past(stages_q[STAGES-1])) && (serialOutInv == !serialOut);
  endproperty
  a_out: assert property (p_out) else $error("serial outputs wrong");

  property p_width;
    @(posedge clock) disable iff (!reset_n)
      !loadN ##1 !loadN |=> stages_q[STAGES-1] == $past(parS[STAGES-1]);
  endproperty
  a_width: assert property (p_width) else $error("last stage not loaded");

  property p_first_stage;
    @(posedge clock) disable iff (!reset_n)
      shiftEvent |=> stages_q[0] == $past(serS);
  endproperty
  a_first_stage: assert property (p_first_stage) else $error("first stage wrong");

  property p_load_no_shift;
    @(posedge clock) disable iff (!reset_n)
      !loadN |-> !shiftEvent;
  endproperty
  a_load_no_shift: assert property (p_load_no_shift) else $error("shift during load");

  property p_par_ignored;
    @(posedge clock) disable iff (!reset_n)
      (primed_q && loadN && !shiftEvent && $changed(parS)) |=> $stable(stages_q);
  endproperty
  a_par_ignored: assert property (p_par_ignored) else $error("parallel pins leaked");

  property p_inh_late;
    @(posedge clock) disable iff (!reset_n)
      (clkS && clkPrev_q && inhS && !inhPrev_q) |-> !shiftEvent;
  endproperty
  a_inh_late: assert property (p_inh_late) else $error("late inhibit shifted");

  property p_clk_high_hold;
    @(posedge clock) disable iff (!reset_n)
      (primed_q && loadN && clkS && clkPrev_q) |=> $stable(stages_q);
  endproperty
  a_clk_high_hold: assert property (p_clk_high_hold) else $error("moved with clock high");

  property p_inh_high_hold;
    @(posedge clock) disable iff (!reset_n)
      (primed_q && loadN && inhS && inhPrev_q) |=> $stable(stages_q);
  endproperty
  a_inh_high_hold: assert property (p_inh_high_hold) else $error("moved with inhibit high");

  property p_ser_ignored;
    @(posedge clock) disable iff (!reset_n)
      (primed_q && loadN && !shiftEvent && $changed(serS)) |=> $stable(stages_q);
  endproperty
  a_ser_ignored: assert property (p_ser_ignored) else $error("serial pin leaked");

  property p_out_quiet;
    @(posedge clock) disable iff (!reset_n)
      (primed_q && $stable(stages_q[STAGES-1])) |=> $stable(serialOut);
  endproperty
  a_out_quiet: assert property (p_out_quiet) else $error("output moved alone");

  property p_single_shift;
    @(posedge clock) disable iff (!reset_n)
      shiftEvent |=> !shiftEvent;
  endproperty
  a_single_shift: assert property (p_single_shift) else $error("two shifts for one edge");

  property p_out_inverse;
    @(posedge clock) disable iff (!reset_n)
      primed_q |=> serialOutInv == !$past(stages_q[STAGES-1]);
  endproperty
  a_out_inverse: assert property (p_out_inverse) else $error("inverted output wrong");
endmodule : parallel_in_serial_out_shifter
`default_nettype wire

// file: sim/ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module ctrl_model (
  // Clock
  input wire logic clock,
  // Pins
  output var logic loadN,
  output var logic linkClock,
  output var logic inhibit,
  output var logic serData
);
  initial begin
    loadN = 1'b1;
    linkClock = 1'b0;
    inhibit = 1'b0;
    serData = 1'b0;
  end
  task hold(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : hold
  task load(input logic clkHigh);
    loadN = 1'b0;
    linkClock = clkHigh;
    hold(12);
    loadN = 1'b1;
    hold(12);
    linkClock = 1'b0;
    hold(13);
  endtask : load
  // One link period of 125 ns: 65 ns low, 60 ns high
  task shift(input logic d, input logic viaInh);
    serData = d;
    hold(13);
    if (viaInh) inhibit = 1'b1;
    else linkClock = 1'b1;
    hold(12);
    inhibit = 1'b0;
    linkClock = 1'b0;
  endtask : shift
  // First clock edge shifts d in; the edge under inhibit must not
  task blocked(input logic d);
    serData = d;
    hold(13);
    linkClock = 1'b1;
    hold(12);
    inhibit = 1'b1;
    hold(12);
    linkClock = 1'b0;
    hold(13);
    linkClock = 1'b1;
    hold(12);
    linkClock = 1'b0;
    hold(13);
    inhibit = 1'b0;
    hold(13);
  endtask : blocked
endmodule : ctrl_model
`default_nettype wire

// file: sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import piso_shifter_pkg::*;
  logic clock, reset_n, loadN, linkClock, inhibit, serData, serialOut, serialOutInv, d;
  logic [7:0] parallelIn, expReg;
  int failures, checks_done, seed;
  ctrl_model u_ctrl_model (.clock(clock), .loadN(loadN), .linkClock(linkClock),
    .inhibit(inhibit), .serData(serData));
  parallel_in_serial_out_shifter u_parallel_in_serial_out_shifter (.clock(clock),
    .reset_n(reset_n), .load_control_n(loadN), .linkClock(linkClock),
    .clock_inhibit(inhibit), .first_stage_data_in(serData), .parallelIn(parallelIn),
    .serialOut(serialOut), .serialOutInv(serialOutInv));
  function automatic logic [1:0] expOut(input logic [7:0] r);
    return {r[7], ~r[7]};
  endfunction : expOut
  task check(input logic [1:0] seen, input logic [1:0] want);
    checks_done++;
    if (seen !== want) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  // ****
  // Clock, watchdog, sequence
  // ****
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    #50000;
    failures++;
    end_of_test();
  end
  initial begin
    seed = 32'h489f0965;
    reset_n = 1'b0;
    parallelIn = 8'h00;
    repeat (4) @(posedge clock);
    #1 reset_n = 1'b1;
    for (int t = 0; t < 6; t++) begin
      parallelIn = (t == 0) ? 8'h80 : (t == 1) ? 8'h7f : 8'($random(seed));
      expReg = parallelIn;
      u_ctrl_model.load(t[0]);
      check({serialOut, serialOutInv}, expOut(expReg));
      for (int i = 0; i < 8; i++) begin
        d = 1'($random(seed));
        parallelIn = 8'($random(seed));
        u_ctrl_model.shift(d, i[0]);
        expReg = {expReg[6:0], d};
        if (i[0]) check({serialOut, serialOutInv}, expOut(expReg));
        else check({serialOut, serialOutInv}, expOut(expReg));
      end
      d = 1'($random(seed));
      u_ctrl_model.blocked(d);
      expReg = {expReg[6:0], d};
      check({serialOut, serialOutInv}, expOut(expReg));
    end
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
